/* File: pbs_burst_ctr.sv */
// two-bit burst address sequencer
`timescale 1ns/10ps
module pbs_burst_ctr (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic       step,
  input  wire logic       linear,
  input  wire logic [1:0] startLow,
  output logic      [1:0] curLow,
  output logic      [1:0] nextLow
);
  logic [1:0] start_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  assign cnt_nxt = 2'(cnt_r + 2'h1);
  // [R13] xor or modulo-four add
  assign curLow  = linear ? 2'(start_r + cnt_r) : (start_r ^ cnt_r);
  assign nextLow = linear ? 2'(start_r + cnt_nxt) : (start_r ^ cnt_nxt);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      start_r <= 2'h0;
      cnt_r   <= 2'h0;
    end else if (load) begin
      start_r <= startLow;
      cnt_r   <= 2'h0;
    end else if (step) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* File: pbs_bus_if.sv */
// synchronous sram bus between controller and memory
`timescale 1ns/10ps
interface pbs_bus_if #(
  parameter int AW = pbs_pkg::ADDR_W,
  parameter int DW = pbs_pkg::DATA_W,
  parameter int NL = pbs_pkg::LANES
);
  logic [AW-1:0] addr;
  logic          masterSelN;
  logic          selectHigh;
  logic          selectLowN;
  logic          procStrobeN;
  logic          ctrlStrobeN;
  logic          burstStepN;
  logic          allWriteN;
  logic          byteGateN;
  logic [NL-1:0] laneWriteN;
  logic          outEnN;
  logic          sleepOut;
  logic          sleepOe;
  logic          orderOut;
  logic          orderOe;
  logic [DW-1:0] hostDq;
  logic          hostDqOe;
  logic [DW-1:0] devDq;
  logic          devDqOe;
  logic          sleepRequest;
  logic          burstOrderSelect;
  logic [DW-1:0] dq;
  // ---------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------
  // [R19] pull-down on sleep
  assign sleepRequest = sleepOe ? sleepOut : 1'b0;
  // [R12] pull-up on order select
  assign burstOrderSelect = orderOe ? orderOut : 1'b1;
  // nobody driving reads as zero
  assign dq = devDqOe ? devDq : (hostDqOe ? hostDq : '0);
  modport dev (
    input  addr, masterSelN, selectHigh, selectLowN, procStrobeN,
    input  ctrlStrobeN, burstStepN, allWriteN, byteGateN, laneWriteN,
    input  outEnN, sleepRequest, burstOrderSelect, dq,
    output devDq, devDqOe
  );
  modport host (
    output addr, masterSelN, selectHigh, selectLowN, procStrobeN,
    output ctrlStrobeN, burstStepN, allWriteN, byteGateN, laneWriteN,
    output outEnN, sleepOut, sleepOe, orderOut, orderOe,
    output hostDq, hostDqOe,
    input  dq
  );
endinterface

/* File: pbs_link_chk.sv */
// assertions on the sram link between controller and memory
`timescale 1ns/10ps
module pbs_link_chk (
  input wire logic                     clock,
  input wire logic                     sys_rst,
  input wire logic                     masterSelN,
  input wire logic                     selectHigh,
  input wire logic                     selectLowN,
  input wire logic                     procStrobeN,
  input wire logic                     ctrlStrobeN,
  input wire logic                     allWriteN,
  input wire logic                     byteGateN,
  input wire logic [pbs_pkg::LANES-1:0] laneWriteN,
  input wire logic                     outEnN,
  input wire logic                     sleepOe,
  input wire logic                     sleepRequest,
  input wire logic                     devDqOe,
  input wire logic                     hostDqOe
);
  wire selOk = !masterSelN && selectHigh && !selectLowN;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // link rules
  // ---------------------------------------------------------------
  // floating sleep reads low
  chk_sleep_pull_low: assert property (!sleepOe |-> !sleepRequest)
    else $error("sleep request not pulled low");
  chk_sleep_release: assert property (sleepRequest[*4] |=> !devDqOe)
    else $error("data driven while sleeping");
  chk_oe_release: assert property (outEnN[*3] |=> !devDqOe)
    else $error("data driven with output disabled");
  chk_no_fight: assert property (!(devDqOe && hostDqOe))
    else $error("both ends drive data");
  // host data only with outputs off
  chk_host_oe_off: assert property (hostDqOe |-> outEnN)
    else $error("host drives data with output enabled");
  // read data two edges after start
  chk_read_lat: assert property (!outEnN[*4] ##0
    (selOk && !procStrobeN && !sleepRequest) |-> ##2 devDqOe)
    else $error("read data not driven on time");
  // one extra driven cycle after deselect
  chk_desel_tail: assert property (!outEnN[*4] ##0
    (selOk && !procStrobeN) ##1 (!ctrlStrobeN && masterSelN)
    |-> ##2 devDqOe ##1 !devDqOe)
    else $error("deselect tail length wrong");
  chk_write_off: assert property (selOk && !ctrlStrobeN &&
    procStrobeN && (!allWriteN || (!byteGateN && laneWriteN != '1))
    |=> !devDqOe)
    else $error("outputs on after write start");
endmodule

/* File: pbs_pkg.sv */
// shared constants and types for the pipelined burst sram port
package pbs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 36;
  localparam int LANES  = 4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS          = 8;
  localparam int SNOOZE_EXIT_NS  = 40;
  localparam int SNOOZE_EXIT_CYC = (SNOOZE_EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TURN_CYC        = 3;
  localparam logic [1:0] SYNC_HI = 2'h3;
  localparam logic [1:0] SYNC_LO = 2'h0;
  // ---------------------------------------------------------------
  // controller register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_WR     = 1;
  localparam int CTRL_LEN    = 2;
  localparam int CTRL_LINEAR = 4;
  localparam int CTRL_SLEEP  = 5;
  localparam int CTRL_LANE   = 8;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_SLEEP  = 1;
  localparam int STAT_RECOV  = 2;
  localparam int HTRANS_ACT  = 1;
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_TURN  = 5'h02,
    H_START = 5'h04,
    H_BEAT  = 5'h08,
    H_DRAIN = 5'h10
  } pbs_hstate_e;
endpackage

/* File: pbs_sram_dev.sv */
// memory end: burst sram with pipelined reads
`timescale 1ns/10ps
// Rules of the sram link that this block works under
// [R01] clocked inputs except enable, sleep, order
// [R02] address taken when selected and strobed
// [R03] master select gates processor strobe only
// [R04] second select high-active, third low-active
// [R05] processor strobe loads address or deselects
// [R06] controller strobe loads address or deselects
// [R07] burst step low advances burst address
// [R08] all-bytes write writes whole word
// [R09] lane writes need byte gate low
// [R10] no lane selected means read
// [R11] drive data only when enabled and reading
// [R12] order select high interleaved, low linear
// [R13] four-address interleaved or linear sequence
// [R14] sleep request deselects, retains data
// [R15] sleeping ignores inputs, releases outputs
// [R16] host finishes operations before sleeping
// [R17] no writes during sleep exit recovery
// [R18] host disables outputs before writing
// [R19] sleep request pulled low
// [R20] read data out one edge after address
// [R21] step ignored on strobe edge
// [R22] controller cycle samples writes same edge
// [R23] lane write disables outputs, loads data
// [R24] read data held one extra cycle
module pbs_sram_dev #(
  parameter int AW = pbs_pkg::ADDR_W,
  parameter int DW = pbs_pkg::DATA_W,
  parameter int NL = pbs_pkg::LANES
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  pbs_bus_if.dev    bus,
  output logic      inSnooze,
  output logic      cycleActive
);
  localparam int LW = DW / NL;
  // ---------------------------------------------------------------
  // asynchronous pins
  // ---------------------------------------------------------------
  logic [1:0] oeSync_r;
  logic [1:0] sleepSync_r;
  logic [1:0] orderSync_r;
  // [R01] async pins through two flops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      oeSync_r    <= pbs_pkg::SYNC_HI;
      sleepSync_r <= pbs_pkg::SYNC_LO;
      orderSync_r <= pbs_pkg::SYNC_HI;
    end else begin
      oeSync_r    <= {oeSync_r[0], bus.outEnN};
      sleepSync_r <= {sleepSync_r[0], bus.sleepRequest};
      orderSync_r <= {orderSync_r[0], bus.burstOrderSelect};
    end
  end
  logic sleepNow;
  logic outEnable;
  logic linearOrder;
  assign sleepNow    = sleepSync_r[1];
  assign outEnable   = !oeSync_r[1];
  // [R12] low select means linear
  assign linearOrder = !orderSync_r[1];
  // ---------------------------------------------------------------
  // cycle decode
  // ---------------------------------------------------------------
  logic          procStart;
  logic          ctrlStart;
  logic          chipSel;
  logic          startEdge;
  logic          loadEdge;
  logic          contEdge;
  logic          stepNow;
  logic [NL-1:0] laneWr;
  logic [NL-1:0] wrLanes;
  logic          rdIssue;
  always_comb begin
    // [R03] master select blocks processor strobe
    procStart = !bus.procStrobeN && !bus.masterSelN;
    // [R22] controller start needs processor strobe idle
    ctrlStart = !bus.ctrlStrobeN && !procStart;
    // [R04] select polarities
    chipSel   = !bus.masterSelN && bus.selectHigh && !bus.selectLowN;
    // [R15] sleeping ignores every strobe
    // [R05] [R06] strobe starts cycle or deselect
    startEdge = !sleepNow && (procStart || ctrlStart);
    // [R02] address captured only when selected
    loadEdge  = startEdge && chipSel;
    // [R21] continue only with both strobes high
    contEdge  = !sleepNow && cycleActive && bus.ctrlStrobeN
                && (bus.procStrobeN || bus.masterSelN);
    // [R07] step low advances
    stepNow   = contEdge && !bus.burstStepN;
    // [R08] all-bytes write overrides lanes
    // [R09] byte gate high means read
    // [R10] lanes low are written
    if (!bus.allWriteN) begin
      laneWr = '1;
    end else if (bus.byteGateN) begin
      laneWr = '0;
    end else begin
      laneWr = ~bus.laneWriteN;
    end
    // [R23] processor start ignores lane writes
    if ((loadEdge && !procStart) || contEdge) begin
      wrLanes = laneWr;
    end else begin
      wrLanes = '0;
    end
    rdIssue = (loadEdge || contEdge) && (wrLanes == '0);
  end
  // ---------------------------------------------------------------
  // burst address
  // ---------------------------------------------------------------
  logic [1:0]    curLow;
  logic [1:0]    nextLow;
  logic [AW-3:0] baseHi_r;
  logic [AW-1:0] accAddr;
  pbs_burst_ctr u_burst (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .load     (loadEdge),
    .step     (stepNow),
    .linear   (linearOrder),
    .startLow (bus.addr[1:0]),
    .curLow   (curLow),
    .nextLow  (nextLow)
  );
  assign accAddr = loadEdge ? bus.addr
                 : {baseHi_r, (stepNow ? nextLow : curLow)};
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      baseHi_r <= '0;
    end else if (loadEdge) begin
      baseHi_r <= bus.addr[AW-1:2];
    end
  end
  // [R14] sleep or deselect ends the burst
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cycleActive <= 1'b0;
    end else if (sleepNow) begin
      cycleActive <= 1'b0;
    end else if (startEdge) begin
      cycleActive <= chipSel;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      inSnooze <= 1'b0;
    end else begin
      inSnooze <= sleepNow;
    end
  end
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // array has no reset; contents survive sleep
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // [R23] write data loaded per lane
  always_ff @(posedge clock) begin
    for (int l = 0; l < NL; l++) begin
      if (wrLanes[l]) begin
        mem[accAddr][l*LW +: LW] <= bus.dq[l*LW +: LW];
      end
    end
  end
  // ---------------------------------------------------------------
  // read pipeline
  // ---------------------------------------------------------------
  logic [AW-1:0] rdAddr_r;
  logic          rdStage_r;
  logic          tail_r;
  logic [DW-1:0] dqOut_r;
  logic          dqOe_r;
  // [R20] address stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdAddr_r  <= '0;
      rdStage_r <= 1'b0;
    end else begin
      rdStage_r <= rdIssue;
      if (rdIssue) begin
        rdAddr_r <= accAddr;
      end
    end
  end
  // [R24] one more cycle after a read ends
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tail_r <= 1'b0;
    end else begin
      tail_r <= rdStage_r && !rdIssue && !sleepNow;
    end
  end
  // [R20] data stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dqOut_r <= '0;
    end else if (rdStage_r) begin
      dqOut_r <= mem[rdAddr_r];
    end
  end
  // [R11] enable follows read state and enable pin
  // [R15] released while sleeping
  // [R23] any lane write turns drivers off
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dqOe_r <= 1'b0;
    end else begin
      dqOe_r <= (rdStage_r || tail_r) && outEnable && !sleepNow
                && (wrLanes == '0);
    end
  end
  assign bus.devDq   = dqOut_r;
  assign bus.devDqOe = dqOe_r;
endmodule

/* File: pbs_sram_host.sv */
// controller end: ahb-lite registers driving the sram bus
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module pbs_sram_host #(
  parameter int AW = pbs_pkg::ADDR_W,
  parameter int DW = pbs_pkg::DATA_W,
  parameter int NL = pbs_pkg::LANES
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  pbs_bus_if.host          bus,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  pbs_pkg::pbs_hstate_e st_r;
  logic          regWr_r;
  logic [7:0]    regAddr_r;
  logic          cmdWr_r;
  logic [1:0]    cmdLen_r;
  logic          linear_r;
  logic          sleepReg_r;
  logic [NL-1:0] laneMask_r;
  logic [AW-1:0] addr_r;
  logic [31:0]   wdata_r;
  logic [31:0]   rdata_r;
  logic          goPend_r;
  logic [3:0]    recov_r;
  logic [1:0]    capShift_r;
  logic [2:0]    cnt_r;
  logic [1:0]    beatLeft_r;
  logic          launch;
  logic          ctrlWrite;
  logic [31:0]   rdMux;
  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  always_comb begin
    unique case (haddr[7:0])
      pbs_pkg::REG_ADDR:  rdMux = 32'(addr_r);
      pbs_pkg::REG_WDATA: rdMux = wdata_r;
      pbs_pkg::REG_RDATA: rdMux = rdata_r;
      pbs_pkg::REG_STAT:  rdMux = {29'h0, (recov_r != 4'h0), bus.sleepOut,
                                   (st_r != pbs_pkg::H_IDLE) || goPend_r};
      pbs_pkg::REG_CTRL:  rdMux = {20'h0, 4'(laneMask_r), 2'h0, sleepReg_r,
                                   linear_r, cmdLen_r, cmdWr_r, 1'b0};
      default:            rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regWr_r   <= 1'b0;
      regAddr_r <= 8'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      regWr_r   <= hsel && hready && htrans[pbs_pkg::HTRANS_ACT] && hwrite;
      if (hsel && hready && htrans[pbs_pkg::HTRANS_ACT]) begin
        regAddr_r <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rdMux;
        end
      end
    end
  end
  assign ctrlWrite = regWr_r && (regAddr_r == pbs_pkg::REG_CTRL);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmdWr_r    <= 1'b0;
      cmdLen_r   <= 2'h0;
      linear_r   <= 1'b0;
      sleepReg_r <= 1'b0;
      laneMask_r <= '1;
      addr_r     <= '0;
      wdata_r    <= 32'h0;
    end else if (regWr_r) begin
      if (regAddr_r == pbs_pkg::REG_CTRL) begin
        cmdWr_r    <= hwdata[pbs_pkg::CTRL_WR];
        cmdLen_r   <= hwdata[pbs_pkg::CTRL_LEN +: 2];
        linear_r   <= hwdata[pbs_pkg::CTRL_LINEAR];
        sleepReg_r <= hwdata[pbs_pkg::CTRL_SLEEP];
        laneMask_r <= hwdata[pbs_pkg::CTRL_LANE +: NL];
      end
      if (regAddr_r == pbs_pkg::REG_ADDR) begin
        addr_r <= hwdata[AW-1:0];
      end
      if (regAddr_r == pbs_pkg::REG_WDATA) begin
        wdata_r <= hwdata;
      end
    end
  end
  // a new go wins over the launch that clears it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      goPend_r <= 1'b0;
    end else begin
      goPend_r <= (ctrlWrite && hwdata[pbs_pkg::CTRL_GO])
                  || (goPend_r && !launch);
    end
  end
  // ---------------------------------------------------------------
  // sleep control
  // ---------------------------------------------------------------
  // [R16] sleep only changes with nothing pending
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus.sleepOut <= 1'b0;
      bus.sleepOe  <= 1'b0;
      recov_r      <= 4'h0;
    end else begin
      // [R19] pin left to the pull-down unless sleep wanted
      if (st_r == pbs_pkg::H_IDLE && !goPend_r) begin
        bus.sleepOut <= sleepReg_r;
        bus.sleepOe  <= sleepReg_r;
      end
      // [R17] writes held off during exit recovery
      if (bus.sleepOut && !sleepReg_r && st_r == pbs_pkg::H_IDLE
          && !goPend_r) begin
        recov_r <= 4'(pbs_pkg::SNOOZE_EXIT_CYC);
      end else if (recov_r != 4'h0) begin
        recov_r <= 4'(recov_r - 4'h1);
      end
    end
  end
  assign launch = (st_r == pbs_pkg::H_IDLE) && goPend_r && !bus.sleepOut
                  && !sleepReg_r && (!cmdWr_r || recov_r == 4'h0);
  // ---------------------------------------------------------------
  // read capture, two edges after each read beat
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      capShift_r <= 2'h0;
      rdata_r    <= 32'h0;
    end else begin
      capShift_r <= {capShift_r[0], !cmdWr_r &&
                     (st_r == pbs_pkg::H_START || st_r == pbs_pkg::H_BEAT)};
      if (capShift_r[1]) begin
        rdata_r <= bus.dq[31:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // bus sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r            <= pbs_pkg::H_IDLE;
      cnt_r           <= 3'h0;
      beatLeft_r      <= 2'h0;
      bus.addr        <= '0;
      bus.masterSelN  <= 1'b1;
      bus.selectHigh  <= 1'b1;
      bus.selectLowN  <= 1'b0;
      bus.procStrobeN <= 1'b1;
      bus.ctrlStrobeN <= 1'b1;
      bus.burstStepN  <= 1'b1;
      bus.allWriteN   <= 1'b1;
      bus.byteGateN   <= 1'b1;
      bus.laneWriteN  <= '1;
      bus.outEnN      <= 1'b0;
      bus.orderOut    <= 1'b1;
      bus.orderOe     <= 1'b1;
      bus.hostDq      <= '0;
      bus.hostDqOe    <= 1'b0;
    end else begin
      // [R12] pull-up alone gives interleaved order
      bus.orderOut <= !linear_r;
      bus.orderOe  <= linear_r;
      unique case (st_r)
        pbs_pkg::H_IDLE: begin
          if (launch) begin
            beatLeft_r <= cmdLen_r;
            // [R18] outputs off before write data
            bus.outEnN <= cmdWr_r;
            cnt_r      <= 3'(pbs_pkg::TURN_CYC);
            st_r       <= pbs_pkg::H_TURN;
          end
        end
        pbs_pkg::H_TURN: begin
          cnt_r <= 3'(cnt_r - 3'h1);
          if (cnt_r == 3'h1) begin
            bus.addr       <= addr_r;
            bus.masterSelN <= 1'b0;
            if (cmdWr_r) begin
              // [R06] [R22] controller strobe, writes same edge
              bus.ctrlStrobeN <= 1'b0;
              bus.allWriteN   <= !(laneMask_r == '1);
              bus.byteGateN   <= 1'b0;
              bus.laneWriteN  <= ~laneMask_r;
              bus.hostDq      <= DW'(wdata_r);
              bus.hostDqOe    <= 1'b1;
            end else begin
              // [R05] processor strobe loads read address
              bus.procStrobeN <= 1'b0;
            end
            st_r <= pbs_pkg::H_START;
          end
        end
        pbs_pkg::H_START, pbs_pkg::H_BEAT: begin
          bus.procStrobeN <= 1'b1;
          if (beatLeft_r != 2'h0) begin
            // [R07] [R21] step with both strobes high
            bus.ctrlStrobeN <= 1'b1;
            bus.burstStepN  <= 1'b0;
            beatLeft_r      <= 2'(beatLeft_r - 2'h1);
            st_r            <= pbs_pkg::H_BEAT;
          end else begin
            // deselect: controller strobe with master off
            bus.ctrlStrobeN <= 1'b0;
            bus.masterSelN  <= 1'b1;
            bus.burstStepN  <= 1'b1;
            bus.allWriteN   <= 1'b1;
            bus.byteGateN   <= 1'b1;
            bus.laneWriteN  <= '1;
            bus.hostDqOe    <= 1'b0;
            cnt_r           <= 3'(pbs_pkg::TURN_CYC);
            st_r            <= pbs_pkg::H_DRAIN;
          end
        end
        pbs_pkg::H_DRAIN: begin
          bus.ctrlStrobeN <= 1'b1;
          bus.outEnN      <= 1'b0;
          cnt_r           <= 3'(cnt_r - 3'h1);
          if (cnt_r == 3'h1) begin
            st_r <= pbs_pkg::H_IDLE;
          end
        end
        default: st_r <= pbs_pkg::H_IDLE;
      endcase
    end
  end
endmodule

/* File: pipelined_burst_sram_port_test.sv */
// bench: ahb-lite controller and sram memory joined by the link
`timescale 1ns/10ps
module pipelined_burst_sram_port_test;
  logic        clock;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        inSnooze;
  logic        cycleActive;
  logic [31:0] q;
  logic [31:0] mem [4];
  int          bad_count;
  int          tests_run;
  pbs_bus_if bus ();
  pbs_sram_host pbs_sram_host_inst (.clock(clock), .sys_rst(sys_rst),
    .bus(bus), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  pbs_sram_dev pbs_sram_dev_inst (.clock(clock), .sys_rst(sys_rst),
    .bus(bus), .inSnooze(inSnooze), .cycleActive(cycleActive));
  pbs_link_chk pbs_link_chk_inst (.clock(clock), .sys_rst(sys_rst),
    .masterSelN(bus.masterSelN), .selectHigh(bus.selectHigh),
    .selectLowN(bus.selectLowN), .procStrobeN(bus.procStrobeN),
    .ctrlStrobeN(bus.ctrlStrobeN), .allWriteN(bus.allWriteN),
    .byteGateN(bus.byteGateN), .laneWriteN(bus.laneWriteN),
    .outEnN(bus.outEnN), .sleepOe(bus.sleepOe),
    .sleepRequest(bus.sleepRequest), .devDqOe(bus.devDqOe),
    .hostDqOe(bus.hostDqOe));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // hready read as the rising edge samples it, before that edge's updates
  task waitRdy;
    int i;
    i = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        bad_count++;
        summarize();
      end
      @(posedge clock);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask
  task waitStat(input int b, input logic v);
    for (int i = 0; i < 60; i++) begin
      ahb(1'b0, pbs_pkg::REG_STAT, 32'h0);
      if (q[b] === v) return;
    end
    bad_count++;
    summarize();
  endtask
  task op(input logic w, input logic [15:0] a, input logic [31:0] d,
          input logic [1:0] len, input logic lin, input logic [3:0] ln);
    ahb(1'b1, pbs_pkg::REG_WDATA, d);
    ahb(1'b1, pbs_pkg::REG_ADDR, {16'h0, a});
    ahb(1'b1, pbs_pkg::REG_CTRL, {20'h0, ln, 3'h0, lin, len, w, 1'b1});
    waitStat(pbs_pkg::STAT_BUSY, 1'b1);
    waitStat(pbs_pkg::STAT_BUSY, 1'b0);
    ahb(1'b0, pbs_pkg::REG_RDATA, 32'h0);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_full;
    for (int i = 0; i < 4; i++) begin
      mem[i] = 32'h1111_1111 * (i + 1);
      op(1'b1, 16'h0120 + 16'(i), mem[i], 2'h0, 1'b0, 4'hf);
    end
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 16'h0120 + 16'(i), 32'h0, 2'h0, 1'b0, 4'hf);
      cmp("single read", mem[i], q);
    end
  endtask
  // last beat shows where the burst order went
  task t_burst;
    logic [1:0] e;
    for (int lin = 0; lin < 2; lin++) begin
      for (int len = 1; len < 4; len += 2) begin
        e = lin[0] ? 2'(2'h1 + len[1:0]) : (2'h1 ^ len[1:0]);
        op(1'b0, 16'h0121, 32'h0, len[1:0], lin[0], 4'hf);
        cmp("burst last beat", mem[e], q);
      end
    end
  endtask
  task t_lane;
    op(1'b1, 16'h0123, 32'hffff_ffff, 2'h0, 1'b0, 4'h1);
    op(1'b0, 16'h0123, 32'h0, 2'h0, 1'b0, 4'hf);
    // lanes are nine bits wide, so lane zero reaches bit 8
    mem[3][pbs_pkg::DATA_W/pbs_pkg::LANES-1:0] = '1;
    cmp("one lane write", mem[3], q);
    // no lane chosen must leave memory alone
    op(1'b1, 16'h0123, 32'h0, 2'h0, 1'b0, 4'h0);
    op(1'b0, 16'h0123, 32'h0, 2'h0, 1'b0, 4'hf);
    cmp("empty lane mask", mem[3], q);
  endtask
  task t_sleep;
    ahb(1'b1, pbs_pkg::REG_CTRL, 32'h0000_0f20);
    waitStat(pbs_pkg::STAT_SLEEP, 1'b1);
    ahb(1'b0, pbs_pkg::REG_STAT, 32'h0);
    cmp("snooze seen", 32'h1, {31'h0, inSnooze});
    cmp("burst closed in snooze", 32'h0, {31'h0, cycleActive});
    ahb(1'b1, pbs_pkg::REG_CTRL, 32'h0000_0f00);
    waitStat(pbs_pkg::STAT_RECOV, 1'b0);
    op(1'b0, 16'h0120, 32'h0, 2'h0, 1'b0, 4'hf);
    cmp("data kept in snooze", mem[0], q);
  endtask
  task t_unmapped;
    ahb(1'b0, 8'h40, 32'h0);
    cmp("unmapped read", 32'h0, q);
    cmp("response okay", 32'h0, {31'h0, hresp});
  endtask
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    t_full();
    t_burst();
    t_lane();
    t_sleep();
    t_unmapped();
    summarize();
  end
endmodule
